// ---- hw/eee_np_defines.svh ----
`ifndef EEE_NP_DEFINES_SVH
`define EEE_NP_DEFINES_SVH
// register byte offsets
`define OFS_NP_RX 8'h00ea
`define OFS_ADVERT 8'h00ec
`define OFS_WAKE_ERR 8'h00ee
`define OFS_IRQ_STATUS 8'h00f8
`define OFS_IRQ_MASK 8'h00fc
// received page fields
`define NP_MORE_BIT 15
`define NP_ACK_BIT 14
`define NP_MSG_BIT 13
`define NP_COMPLY_BIT 12
`define NP_TOGGLE_BIT 11
`define NP_CODE_MSB 10
`define NP_CODE_RESET 11'h000
// advertisement fields
`define ADV_LOCAL_TX_BIT 1
`define ADV_LOCAL_TX_RESET 1'b1
`define ADV_LOCAL_UNSUP_MSB 6
`define ADV_LOCAL_UNSUP_LSB 2
`define ADV_PARTNER_MSB 14
`define ADV_PARTNER_LSB 9
// wake error counter
`define WAKE_ERR_RESET 16'h0000
`define WAKE_ERR_MAX 16'hffff
`define WAKE_LIMIT_NS 20500
// interrupt status bits
`define IRQ_PAGE_BIT 0
`define IRQ_WAKE_BIT 1
`define IRQ_SAT_BIT 2
`define IRQ_WIDTH 3
`endif

// ---- hw/eee_np_pkg.sv ----
package eee_np_pkg;
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ACK = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;
endpackage

// ---- hw/port_eee_nextpage_status_regs.sv ----
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "eee_np_defines.svh"
// Summary of operation
// - bit 15 keeps partner more-pages flag
// - bit 14 ack, set after consistent bursts
// - bit 13 marks message versus unformatted page
// - bit 12 is partner comply-ability flag
// - toggle bit inverts previous codeword toggle
// - first toggle inverts base codeword bit 11
// - low eleven bits code field, reset zero
// - bits 9-14 show partner eee abilities
// - local bits 2-6 read-only zero
// - bit 1 writable, resets to one
// - no eee in fiber mode
// - count rising edges of wake-timer-expired
// - counted wake exceeded wake limit time
// - counter saturates at all ones
// - read returns value, then clears counter
// - partner next pages stored here
module port_eee_nextpage_status_regs #(
  parameter int CLK_HZ = 50000000,
  parameter int CNT_W = 16
) (
  input wire logic clk_i, // 50 MHz clock
  input wire logic rstn_i, // async reset, active low
  input wire logic [7:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic np_valid_i, // one-cycle strobe, page word valid
  input wire logic [15:0] np_word_i, // received page codeword
  input wire logic [5:0] partner_abil_i, // partner eee abilities
  input wire logic fiber_mode_i, // port runs fiber
  input wire logic wake_timer_done_i, // wake timer expired level
  output logic irq_o // level interrupt
);
  localparam int WAKE_CYC = (`WAKE_LIMIT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  eee_np_pkg::bus_state_t st_r;
  logic more_r;
  logic ack_r;
  logic msg_r;
  logic comply_r;
  logic toggle_r;
  logic [`NP_CODE_MSB:0] code_r;
  logic [15:0] np_rx_word;
  logic [5:0] partner_r;
  logic adv_tx_r;
  logic [CNT_W-1:0] wake_cnt_r;
  logic wake_d_r;
  logic page_st_r;
  logic wake_st_r;
  logic sat_st_r;
  logic [`IRQ_WIDTH-1:0] irq_st;
  logic mask_page_r;
  logic mask_wake_r;
  logic mask_sat_r;
  logic [`IRQ_WIDTH-1:0] irq_mask;
  logic sat_hit;
  logic [31:0] rdata_nxt;
  logic wake_rise;
  logic cnt_clr;
  logic cnt_inc;
  logic acc;
  logic wr_go;
  logic rd_go;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ==========================================================
  // readback words
  // ==========================================================
  // each register sits in the low half of a 32-bit word; the upper
  // half and every bit not set here read zero
  function automatic logic [31:0] np_word(input logic [15:0] page);
    np_word = 32'h0000_0000;
    np_word[15:0] = page;
  endfunction

  function automatic logic [31:0] advert_word(input logic [5:0] partner, input logic local_tx);
    advert_word = 32'h0000_0000;
    advert_word[`ADV_PARTNER_MSB:`ADV_PARTNER_LSB] = partner;
    advert_word[`ADV_LOCAL_UNSUP_MSB:`ADV_LOCAL_UNSUP_LSB] = 5'h00;
    advert_word[`ADV_LOCAL_TX_BIT] = local_tx;
  endfunction

  function automatic logic [31:0] wake_word(input logic [CNT_W-1:0] count);
    wake_word = 32'h0000_0000;
    wake_word[CNT_W-1:0] = count;
  endfunction

  // shared by the status and the mask register, which have one layout
  function automatic logic [31:0] irq_word(input logic [`IRQ_WIDTH-1:0] bits);
    irq_word = 32'h0000_0000;
    irq_word[`IRQ_WIDTH-1:0] = bits;
  endfunction

  // ==========================================================
  // address decode
  // ==========================================================
  // only exact byte offsets decode; the odd half of each register is
  // a hole, so a misaligned access can never alias onto a neighbour
  logic sel_np;
  logic sel_adv;
  logic sel_wake;
  logic sel_irq_st;
  logic sel_irq_mask;

  logic lane0_wr;
  logic wr_adv;
  logic wr_irq_st;
  logic wr_irq_mask;
  logic page_take;

  assign sel_np = hit(avs_address_i, `OFS_NP_RX);
  assign sel_adv = hit(avs_address_i, `OFS_ADVERT);
  assign sel_wake = hit(avs_address_i, `OFS_WAKE_ERR);
  assign sel_irq_st = hit(avs_address_i, `OFS_IRQ_STATUS);
  assign sel_irq_mask = hit(avs_address_i, `OFS_IRQ_MASK);

  // all writable fields live in byte lane 0
  assign lane0_wr = wr_go & avs_byteenable_i[0];
  assign wr_adv = lane0_wr & sel_adv;
  assign wr_irq_st = lane0_wr & sel_irq_st;
  assign wr_irq_mask = lane0_wr & sel_irq_mask;

  // a fiber port has no eee, so a page strobe there is dropped
  assign page_take = np_valid_i & ~fiber_mode_i;

  // ==========================================================
  // bus slave
  // ==========================================================
  // every access gets one wait cycle so read data is registered
  assign acc = (avs_read_i | avs_write_i) & (st_r == eee_np_pkg::BUS_IDLE);
  assign wr_go = avs_write_i & (st_r == eee_np_pkg::BUS_ACK);
  assign rd_go = avs_read_i & (st_r == eee_np_pkg::BUS_ACK);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= eee_np_pkg::BUS_IDLE;
    end else begin
      case (st_r)
        eee_np_pkg::BUS_IDLE: begin
          if (acc) begin
            st_r <= eee_np_pkg::BUS_ACK;
          end
        end
        eee_np_pkg::BUS_ACK: st_r <= eee_np_pkg::BUS_DONE;
        eee_np_pkg::BUS_DONE: st_r <= eee_np_pkg::BUS_IDLE;
        default: st_r <= eee_np_pkg::BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~acc;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (sel_np) begin
      rdata_nxt = np_word(np_rx_word);
    end else if (sel_adv) begin
      rdata_nxt = advert_word(partner_r, adv_tx_r);
    end else if (sel_wake) begin
      rdata_nxt = wake_word(wake_cnt_r);
    end else if (sel_irq_st) begin
      rdata_nxt = irq_word(irq_st);
    end else if (sel_irq_mask) begin
      rdata_nxt = irq_word(irq_mask);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (acc) begin
      avs_readdata_o <= rdata_nxt;
    end
  end

  // ==========================================================
  // received next page
  // ==========================================================
  // the word is stored as received; ack/toggle sequencing is the
  // arbitration logic's job, the register only reflects it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      more_r <= 1'b0;
    end else if (page_take) begin
      more_r <= np_word_i[`NP_MORE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_r <= 1'b0;
    end else if (page_take) begin
      ack_r <= np_word_i[`NP_ACK_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      msg_r <= 1'b0;
    end else if (page_take) begin
      msg_r <= np_word_i[`NP_MSG_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      comply_r <= 1'b0;
    end else if (page_take) begin
      comply_r <= np_word_i[`NP_COMPLY_BIT];
    end
  end

  // the toggle is kept as sent, so software can see a lost page as a
  // toggle that failed to flip
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      toggle_r <= 1'b0;
    end else if (page_take) begin
      toggle_r <= np_word_i[`NP_TOGGLE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_r <= `NP_CODE_RESET;
    end else if (page_take) begin
      code_r <= np_word_i[`NP_CODE_MSB:0];
    end
  end

  assign np_rx_word = {more_r, ack_r, msg_r, comply_r, toggle_r, code_r};

  // ==========================================================
  // advertisement
  // ==========================================================
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      partner_r <= 6'h00;
    end else if (fiber_mode_i) begin
      partner_r <= 6'h00;
    end else if (np_valid_i) begin
      partner_r <= partner_abil_i;
    end
  end

  // disabling eee itself is done through the control register elsewhere
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      adv_tx_r <= `ADV_LOCAL_TX_RESET;
    end else if (wr_adv) begin
      adv_tx_r <= avs_writedata_i[`ADV_LOCAL_TX_BIT];
    end
  end

  // ==========================================================
  // wake error counter
  // ==========================================================
  // the wake timer sized by WAKE_CYC lives outside; its done level is sampled
  assign wake_rise = wake_timer_done_i & ~wake_d_r & ~fiber_mode_i;
  assign cnt_clr = rd_go && sel_wake;
  assign cnt_inc = wake_rise && (wake_cnt_r != CNT_MAX);
  // the event that lifts the counter onto all ones
  assign sat_hit = wake_rise && (wake_cnt_r == CNT_MAX - CNT_W'(1));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_d_r <= 1'b0;
    end else begin
      wake_d_r <= wake_timer_done_i;
    end
  end

  // an event coinciding with the clearing read is kept as a count of one
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_cnt_r <= CNT_W'(`WAKE_ERR_RESET);
    end else if (cnt_clr) begin
      wake_cnt_r <= wake_rise ? CNT_W'(1) : CNT_W'(`WAKE_ERR_RESET);
    end else if (cnt_inc) begin
      wake_cnt_r <= wake_cnt_r + CNT_W'(1);
    end
  end

  // ==========================================================
  // interrupts
  // ==========================================================
  // an event wins over a same-cycle write-one-to-clear, so none is lost
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      page_st_r <= 1'b0;
    end else if (page_take) begin
      page_st_r <= 1'b1;
    end else if (wr_irq_st && avs_writedata_i[`IRQ_PAGE_BIT]) begin
      page_st_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_st_r <= 1'b0;
    end else if (wake_rise) begin
      wake_st_r <= 1'b1;
    end else if (wr_irq_st && avs_writedata_i[`IRQ_WAKE_BIT]) begin
      wake_st_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sat_st_r <= 1'b0;
    end else if (sat_hit) begin
      sat_st_r <= 1'b1;
    end else if (wr_irq_st && avs_writedata_i[`IRQ_SAT_BIT]) begin
      sat_st_r <= 1'b0;
    end
  end

  always_comb begin
    irq_st = '0;
    irq_st[`IRQ_PAGE_BIT] = page_st_r;
    irq_st[`IRQ_WAKE_BIT] = wake_st_r;
    irq_st[`IRQ_SAT_BIT] = sat_st_r;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_page_r <= 1'b0;
    end else if (wr_irq_mask) begin
      mask_page_r <= avs_writedata_i[`IRQ_PAGE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_wake_r <= 1'b0;
    end else if (wr_irq_mask) begin
      mask_wake_r <= avs_writedata_i[`IRQ_WAKE_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_sat_r <= 1'b0;
    end else if (wr_irq_mask) begin
      mask_sat_r <= avs_writedata_i[`IRQ_SAT_BIT];
    end
  end

  always_comb begin
    irq_mask = '0;
    irq_mask[`IRQ_PAGE_BIT] = mask_page_r;
    irq_mask[`IRQ_WAKE_BIT] = mask_wake_r;
    irq_mask[`IRQ_SAT_BIT] = mask_sat_r;
  end

  // registered so the pin never glitches; it lags the status by a cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_st & irq_mask);
    end
  end
endmodule

// ---- test/link_partner_model.sv ----
`timescale 1ns/1ps
module link_partner_model #(
  parameter logic BASE_TOGGLE = 1'b0 // base codeword bit 11
) (
  input wire logic clk_i, // clock
  output logic np_valid_o = 1'b0, // page strobe
  output logic [15:0] np_word_o = 16'h5555, // page word
  output logic [5:0] abil_o = 6'h00, // abilities
  output logic wake_done_o = 1'b0 // wake timer expired
);
  logic tog_r = ~BASE_TOGGLE;
  // ========
  // word lines flip after the strobe so a stale page never looks valid
  task send(input logic [15:0] w, input logic [5:0] a);
    @(posedge clk_i);
    np_valid_o <= 1'b1;
    np_word_o <= {w[15:12], tog_r, w[10:0]};
    abil_o <= a;
    tog_r = ~tog_r;
    @(posedge clk_i);
    np_valid_o <= 1'b0;
    np_word_o <= ~w;
  endtask
  task wake();
    @(posedge clk_i);
    wake_done_o <= 1'b1;
    @(posedge clk_i);
    wake_done_o <= 1'b0;
  endtask
endmodule

// ---- test/port_eee_nextpage_status_regs_tb.sv ----
`timescale 1ns/1ps
`include "eee_np_defines.svh"
module port_eee_nextpage_status_regs_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic fiber = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic npv, wdone, irq, wreq;
  logic [15:0] npw;
  logic [5:0] abil;
  logic [31:0] rdata, q;
  int fail_count = 0;
  int check_count = 0;
  always #10 clk_i = ~clk_i;
  link_partner_model link_partner_model_i (.clk_i(clk_i), .np_valid_o(npv),
    .np_word_o(npw), .abil_o(abil), .wake_done_o(wdone));
  port_eee_nextpage_status_regs port_eee_nextpage_status_regs_i (.clk_i(clk_i),
    .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .np_valid_i(npv), .np_word_i(npw), .partner_abil_i(abil),
    .fiber_mode_i(fiber), .wake_timer_done_i(wdone), .irq_o(irq));
  task tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ========
  // one bus access; the watchdog ends a wait that never finishes
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task irq_chk(input logic e);
    repeat (2) @(negedge clk_i);
    chk({31'h0000_0000, irq}, {31'h0000_0000, e});
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rchk(`OFS_NP_RX, 32'h0000_0000);
    rchk(`OFS_ADVERT, 32'h0000_0002);
    rchk(`OFS_WAKE_ERR, 32'h0000_0000);
    acc(1'b1, `OFS_ADVERT, 32'h0000_fffd);
    rchk(`OFS_ADVERT, 32'h0000_0000);
    acc(1'b1, `OFS_ADVERT, 32'hffff_ffff);
    rchk(`OFS_ADVERT, 32'h0000_0002);
    rchk(8'hf0, 32'h0000_0000);
    link_partner_model_i.send(16'hb001, 6'h3f);
    rchk(`OFS_NP_RX, 32'h0000_b801);
    rchk(`OFS_ADVERT, 32'h0000_7e02);
    irq_chk(1'b0);
    acc(1'b1, `OFS_IRQ_MASK, 32'h0000_0007);
    irq_chk(1'b1);
    acc(1'b1, `OFS_IRQ_STATUS, 32'h0000_0001);
    irq_chk(1'b0);
    link_partner_model_i.send(16'h4c55, 6'h01);
    rchk(`OFS_NP_RX, 32'h0000_4455);
    repeat (3) link_partner_model_i.wake();
    rchk(`OFS_WAKE_ERR, 32'h0000_0003);
    rchk(`OFS_WAKE_ERR, 32'h0000_0000);
    fiber <= 1'b1;
    link_partner_model_i.send(16'h1234, 6'h3f);
    link_partner_model_i.wake();
    rchk(`OFS_NP_RX, 32'h0000_4455);
    rchk(`OFS_ADVERT, 32'h0000_0002);
    rchk(`OFS_WAKE_ERR, 32'h0000_0000);
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end
endmodule

// ---- test/regs_checker_assertions.sv ----
`timescale 1ns/1ps
`include "eee_np_defines.svh"
module regs_checker (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset
  input wire logic [7:0] avs_address_i, // addr
  input wire logic avs_read_i, // rd
  input wire logic avs_write_i, // wr
  input wire logic [31:0] avs_readdata_o, // rdata
  input wire logic avs_waitrequest_o, // stall
  input wire logic fiber_mode_i // fiber
);
  wire logic rd_ack;
  assign rd_ack = avs_read_i && !avs_waitrequest_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ========
  // bus and field checks
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_wait_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
    else $error("ack without request");
  a_ack_within: assert property ($rose(avs_read_i || avs_write_i) |-> ##[1:2] !avs_waitrequest_o)
    else $error("ack late");
  a_rdata_stand: assert property (rd_ack |=> $stable(avs_readdata_o))
    else $error("read data moved");
  a_upper_zero: assert property (
    rd_ack |-> avs_readdata_o[31:16] == 16'h0000) else $error("upper half set");
  a_adv_fixed: assert property (
    rd_ack && avs_address_i == `OFS_ADVERT |-> avs_readdata_o[15] == 1'b0
    && avs_readdata_o[8:2] == 7'h00 && avs_readdata_o[0] == 1'b0) else $error("fixed bits set");
  a_fiber_clear: assert property (
    rd_ack && avs_address_i == `OFS_ADVERT && fiber_mode_i && $past(fiber_mode_i, 2)
    |-> avs_readdata_o[14:9] == 6'h00) else $error("partner bits in fiber");
  a_unmapped_zero: assert property (
    rd_ack && !(avs_address_i inside {`OFS_NP_RX, `OFS_ADVERT, `OFS_WAKE_ERR,
    `OFS_IRQ_STATUS, `OFS_IRQ_MASK}) |-> avs_readdata_o == 32'h0000_0000) else $error("hole read");
endmodule
bind port_eee_nextpage_status_regs regs_checker regs_checker_i (.clk_i(clk_i), .rstn_i(rstn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .fiber_mode_i(fiber_mode_i));
